// ==== essr_pkg.sv ====
// Purpose: Shared constants and types for the exception state registers.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Status word field positions and offsets are named here only.
package essr_pkg;

  localparam int          DW           = 32;
  localparam int          AW           = 12;

  localparam logic [11:0] OFF_ERA      = 12'h000;
  localparam logic [11:0] OFF_FVA      = 12'h004;
  localparam logic [11:0] OFF_PSW      = 12'h008;

  // Status word field positions
  localparam int          B_CU_LO      = 28;
  localparam int          B_RE         = 25;
  localparam int          B_BEV        = 22;
  localparam int          B_TS         = 21;
  localparam int          B_PE         = 20;
  localparam int          B_CM         = 19;
  localparam int          B_PZ         = 18;
  localparam int          B_SWC        = 17;
  localparam int          B_ISC        = 16;
  localparam int          B_IM_LO      = 8;
  localparam int          B_KUO        = 5;
  localparam int          B_IEO        = 4;
  localparam int          B_KUP        = 3;
  localparam int          B_IEP        = 2;
  localparam int          B_KUC        = 1;
  localparam int          B_IEC        = 0;

  localparam int          CU_W         = 4;
  localparam int          IM_W         = 8;
  localparam int          IM_SW_W      = 2;

  // Reset values, fixed read values and other constants
  localparam logic        RST_SWC      = 1'b0;
  localparam logic        RST_KUC      = 1'b0;
  localparam logic        RST_IEC      = 1'b0;
  localparam logic        RST_BEV      = 1'b1;
  localparam logic        TS_VALUE     = 1'b1;
  localparam logic        PE_READ      = 1'b0;
  localparam logic        KERNEL       = 1'b0;
  localparam logic [31:0] ZERO_W       = 32'h0000_0000;
  localparam logic [31:0] SLOT_BACK    = 32'h0000_0004;

  // One exception event from the pipeline
  typedef struct packed {
    logic        take;
    logic        in_slot;
    logic [31:0] pc;
    logic        addr_err;
    logic [31:0] faulting_virtual_address;
  } essr_exc_t;

  // Controls driven to the core
  typedef struct packed {
    logic            kernel;
    logic            vec_uncached;
    logic            user_flip;
    logic            swap;
    logic            isolate;
    logic [CU_W-1:0] cu;
  } essr_ctl_t;

endpackage

// ==== essr_top.sv ====
// Purpose: Exception return address, faulting address and status word.
// Assumes: Core pulses exception and return strobes for one cycle.
// Notes:   APB answers with zero wait states; unmapped reads return zero.
//
// Notes on behaviour
// - Return address register loads the excepting instruction address.
// - In a delay slot, return address points at the preceding branch.
// - Addressing exceptions capture the whole bad virtual address.
// - Taking any exception enters kernel privilege.
// - All status bits read and write, except read-only TLB flag and parity error field.
// - Three-deep privilege and enable stack, push on exception, pop on return.
// - Reset clears swap, current privilege, current enable; sets boot vector, TLB flag.
// - Flip bit reverses user byte order only; kernel keeps reset order.
// - Boot vector select one puts vectors in uncacheable space.
// - TLB off flag always reads one.
// - Parity error field is written one at boot, then always reads zero.
// - Cache miss while isolated sets the isolated-miss flag.
// - Swap bit exchanges instruction and data cache roles.
// - Isolate bit keeps stores out of memory, loads return cache data.
// - Eight mask bits: low two software, upper six external, one enables.
// - Interrupt raises exception only with global enable and mask bit set.
// - Privilege bit zero means kernel, one means user.
// - Enable bit one enables interrupts subject to mask.
// - Reserved status positions read zero; software writes zero.
// - Each usability bit permits user coprocessor operations.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module essr_top
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire essr_pkg::essr_exc_t  exc,
  input  wire logic                 rfe,
  input  wire logic                 dcache_miss,
  input  wire logic [7:0]           irq_pending,
  input  wire logic                 big_endian_strap,
  output logic                      irq_request,
  output logic                      big_endian_now,
  output logic [3:0]                cop_permit,
  output essr_pkg::essr_ctl_t       ctl
);

  logic [31:0] era_q;
  logic [31:0] fva_q;
  logic [3:0]  cu_q;
  logic        re_q;
  logic        bev_q;
  logic        cm_q;
  logic        pz_q;
  logic        swc_q;
  logic        isc_q;
  logic [7:0]  im_q;
  logic [5:0]  stk_q;
  logic        strap_q;
  logic        strap_done_q;
  logic        irq_q;
  logic [31:0] psw;
  logic        wr_en;
  logic        rd_set;
  logic        psw_wr;
  logic        hit;

  // Assemble the readable status word; reserved and parity error read zero
  function automatic logic [31:0] pack_psw(
    input logic [3:0] cu,
    input logic       re,
    input logic       boot_vector_select,
    input logic       cm,
    input logic       pz,
    input logic       cache_swap,
    input logic       cache_isolate,
    input logic [7:0] im,
    input logic [5:0] stk
  );
    logic [31:0] w;
    w = essr_pkg::ZERO_W;
    w[essr_pkg::B_CU_LO +: essr_pkg::CU_W] = cu;
    w[essr_pkg::B_RE]  = re;
    w[essr_pkg::B_BEV] = boot_vector_select;
    w[essr_pkg::B_TS]  = essr_pkg::TS_VALUE;
    w[essr_pkg::B_PE]  = essr_pkg::PE_READ;
    w[essr_pkg::B_CM]  = cm;
    w[essr_pkg::B_PZ]  = pz;
    w[essr_pkg::B_SWC] = cache_swap;
    w[essr_pkg::B_ISC] = cache_isolate;
    w[essr_pkg::B_IM_LO +: essr_pkg::IM_W] = im;
    w[essr_pkg::B_KUO:essr_pkg::B_IEC] = stk;
    return w;
  endfunction

  assign psw = pack_psw(cu_q, re_q, bev_q, cm_q, pz_q,
                        swc_q, isc_q, im_q, stk_q);

  // APB decode; zero wait states
  assign pready = 1'b1;
  assign hit    = (paddr == essr_pkg::OFF_ERA) ||
                  (paddr == essr_pkg::OFF_FVA) ||
                  (paddr == essr_pkg::OFF_PSW);
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite;
  assign rd_set  = psel && !penable && !pwrite;
  assign psw_wr  = wr_en && (paddr == essr_pkg::OFF_PSW);

  // Read data captured in the setup phase so it stands through access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= essr_pkg::ZERO_W;
    end
    else if (rd_set)
    begin
      unique case (paddr)
        essr_pkg::OFF_ERA: prdata <= era_q;
        essr_pkg::OFF_FVA: prdata <= fva_q;
        essr_pkg::OFF_PSW: prdata <= psw;
        default:           prdata <= essr_pkg::ZERO_W;
      endcase
    end
  end

  // Return address; both address registers are read-only to software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      era_q <= essr_pkg::ZERO_W;
    end
    else if (exc.take)
    begin
      if (exc.in_slot)
      begin
        era_q <= exc.pc - essr_pkg::SLOT_BACK;
      end
      else
      begin
        era_q <= exc.pc;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fva_q <= essr_pkg::ZERO_W;
    end
    else if (exc.take && exc.addr_err)
    begin
      fva_q <= exc.faulting_virtual_address;
    end
  end

  // Privilege and enable stack; exception beats a same-cycle write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stk_q <= {4'h0, essr_pkg::RST_KUC, essr_pkg::RST_IEC};
    end
    else if (exc.take)
    begin
      stk_q <= {stk_q[essr_pkg::B_KUP:essr_pkg::B_IEC], essr_pkg::KERNEL, 1'b0};
    end
    else if (rfe)
    begin
      stk_q <= {stk_q[essr_pkg::B_KUO:essr_pkg::B_IEO], stk_q[essr_pkg::B_KUO:essr_pkg::B_IEP]};
    end
    else if (psw_wr)
    begin
      stk_q <= pwdata[essr_pkg::B_KUO:essr_pkg::B_IEC];
    end
  end

  // Plain control fields written directly by software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cu_q  <= 4'h0;
      re_q  <= 1'b0;
      bev_q <= essr_pkg::RST_BEV;
      pz_q  <= 1'b0;
      swc_q <= essr_pkg::RST_SWC;
      isc_q <= 1'b0;
      im_q  <= 8'h00;
    end
    else if (psw_wr)
    begin
      cu_q  <= pwdata[essr_pkg::B_CU_LO +: essr_pkg::CU_W];
      re_q  <= pwdata[essr_pkg::B_RE];
      bev_q <= pwdata[essr_pkg::B_BEV];
      pz_q  <= pwdata[essr_pkg::B_PZ];
      swc_q <= pwdata[essr_pkg::B_SWC];
      isc_q <= pwdata[essr_pkg::B_ISC];
      im_q  <= pwdata[essr_pkg::B_IM_LO +: essr_pkg::IM_W];
    end
  end

  // Isolated miss flag: hardware set wins over a software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cm_q <= 1'b0;
    end
    else if (dcache_miss && isc_q)
    begin
      cm_q <= 1'b1;
    end
    else if (psw_wr)
    begin
      cm_q <= pwdata[essr_pkg::B_CM];
    end
  end

  // Byte order strap caught once after reset release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_q      <= big_endian_strap;
      strap_done_q <= 1'b1;
    end
  end

  // Registered so the request is glitch free toward the core
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= stk_q[essr_pkg::B_IEC] && |(irq_pending & im_q);
    end
  end

  assign irq_request = irq_q;

  // User mode flips only when the privilege bit reads user
  assign big_endian_now = strap_q ^ (re_q && stk_q[essr_pkg::B_KUC]);

  // Kernel always has coprocessor access; user needs the usability bit
  assign cop_permit = cu_q | {essr_pkg::CU_W{!stk_q[essr_pkg::B_KUC]}};

  assign ctl.kernel       = (stk_q[essr_pkg::B_KUC] == essr_pkg::KERNEL);
  assign ctl.vec_uncached = bev_q;
  assign ctl.user_flip    = re_q && stk_q[essr_pkg::B_KUC];
  assign ctl.swap         = swc_q;
  assign ctl.isolate      = isc_q;
  assign ctl.cu           = cu_q;

  // Checks
  sequence s_exc;
    exc.take;
  endsequence

  sequence s_ret;
    !exc.take && rfe;
  endsequence

  sequence s_push_pop;
    s_exc ##1 s_ret;
  endsequence

  chk_exc_kernel: assert property (@(posedge clk) disable iff (rst)
    s_exc |=> ctl.kernel && !stk_q[essr_pkg::B_IEC])
    else $error("exception did not enter kernel");

  chk_stack_push: assert property (@(posedge clk) disable iff (rst)
    s_exc |=> stk_q[5:2] == $past(stk_q[3:0]))
    else $error("stack push wrong");

  chk_stack_pop: assert property (@(posedge clk) disable iff (rst)
    s_ret |=> stk_q == {$past(stk_q[5:4]), $past(stk_q[5:2])})
    else $error("stack pop wrong");

  chk_era_load: assert property (@(posedge clk) disable iff (rst)
    exc.take && !exc.in_slot |=> era_q == $past(exc.pc))
    else $error("return address not loaded");

  chk_era_slot: assert property (@(posedge clk) disable iff (rst)
    exc.take && exc.in_slot |=> era_q == $past(exc.pc) - essr_pkg::SLOT_BACK)
    else $error("delay slot return address wrong");

  chk_fva_load: assert property (@(posedge clk) disable iff (rst)
    exc.take && exc.addr_err |=> fva_q == $past(exc.faulting_virtual_address))
    else $error("faulting address not captured");

  chk_ts_pe_read: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && paddr == essr_pkg::OFF_PSW
    |=> prdata[essr_pkg::B_TS] && !prdata[essr_pkg::B_PE])
    else $error("fixed status bits read wrong");

  chk_cm_set: assert property (@(posedge clk) disable iff (rst)
    dcache_miss && isc_q |=> cm_q)
    else $error("isolated miss flag not set");

  chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irq_request |-> $past(stk_q[essr_pkg::B_IEC]) && |$past(irq_pending & im_q))
    else $error("interrupt raised while masked");

  chk_write_ctl: assert property (@(posedge clk) disable iff (rst)
    psw_wr |=> bev_q == $past(pwdata[essr_pkg::B_BEV]) ##0
      ctl.swap == $past(pwdata[essr_pkg::B_SWC]))
    else $error("status write did not stick");

  chk_reset_vals: assert property (@(posedge clk)
    $fell(rst) |-> bev_q && !swc_q && !stk_q[1] && !stk_q[0])
    else $error("reset values wrong");

  // Two sampled reset edges, so the first edge after power-up is skipped
  chk_reset_hold: assert property (@(posedge clk)
    rst && $past(rst) |-> bev_q && !swc_q && ctl.kernel && !stk_q[essr_pkg::B_IEC])
    else $error("reset state not held");

  chk_stack_restore: assert property (@(posedge clk) disable iff (rst)
    s_push_pop |=> stk_q[essr_pkg::B_KUP:essr_pkg::B_IEC] ==
      $past(stk_q[essr_pkg::B_KUP:essr_pkg::B_IEC], 2))
    else $error("return did not restore the stack");

  // Hold, output and write checks; a reset in mid-attempt cancels them asynchronously
  chk_era_hold: assert property (@(posedge clk) disable iff (rst)
    !exc.take |=> $stable(era_q))
    else $error("return address changed without exception");

  chk_fva_hold: assert property (@(posedge clk) disable iff (rst)
    !(exc.take && exc.addr_err) |=> $stable(fva_q))
    else $error("faulting address changed without address error");

  chk_cm_keep: assert property (@(posedge clk) disable iff (rst)
    !psw_wr && !(dcache_miss && isc_q) |=> $stable(cm_q))
    else $error("isolated miss flag changed on its own");

  chk_irq_raise: assert property (@(posedge clk) disable iff (rst)
    stk_q[essr_pkg::B_IEC] && |(irq_pending & im_q) |=> irq_request)
    else $error("enabled interrupt not raised");

  chk_irq_off: assert property (@(posedge clk) disable iff (rst)
    !stk_q[essr_pkg::B_IEC] |=> !irq_request)
    else $error("interrupt raised while globally disabled");

  chk_cop_user: assert property (@(posedge clk) disable iff (rst)
    !ctl.kernel |-> cop_permit == ctl.cu)
    else $error("user coprocessor permission wrong");

  chk_kernel_order: assert property (@(posedge clk) disable iff (rst)
    ctl.kernel |-> big_endian_now == strap_q)
    else $error("kernel byte order changed");

  chk_flip_user: assert property (@(posedge clk) disable iff (rst)
    !ctl.kernel |-> big_endian_now == (strap_q ^ re_q))
    else $error("user byte order wrong");

  chk_write_fields: assert property (@(posedge clk) disable iff (rst)
    psw_wr |=> im_q == $past(pwdata[essr_pkg::B_IM_LO +: essr_pkg::IM_W]) ##0
      ctl.cu == $past(pwdata[essr_pkg::B_CU_LO +: essr_pkg::CU_W]) ##0
      ctl.isolate == $past(pwdata[essr_pkg::B_ISC]))
    else $error("status field write did not stick");

endmodule // essr_top

// ==== essr_tb.sv ====
// Purpose: Self-checking bench for the exception state registers.
// Assumes: Zero-wait APB slave; core strobes last one cycle.
// Notes:   Status word checks use the layout chosen in the package.
`timescale 1ns/100ps
module tb;
  localparam logic [11:0] ERA = essr_pkg::OFF_ERA;
  localparam logic [11:0] FVA = essr_pkg::OFF_FVA;
  localparam logic [11:0] PSW = essr_pkg::OFF_PSW;

  logic                clk;
  logic                rst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  essr_pkg::essr_exc_t exc;
  logic                rfe;
  logic                dcache_miss;
  logic [7:0]          irq_pending;
  logic                strap;
  logic                irq_request;
  logic                big_endian_now;
  logic [3:0]          cop_permit;
  essr_pkg::essr_ctl_t ctl;
  logic [31:0]         rd;
  logic                err;
  int                  mismatches;
  int                  compares;
  int                  cycles;

  essr_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .exc(exc), .rfe(rfe),
    .dcache_miss(dcache_miss), .irq_pending(irq_pending), .big_endian_strap(strap),
    .irq_request(irq_request), .big_endian_now(big_endian_now), .cop_permit(cop_permit), .ctl(ctl));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Let the edge's register updates land before looking at outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic excp(input logic slot, input logic [31:0] pc, input logic ae, input logic [31:0] va);
    @(posedge clk);
    exc <= '{1'b1, slot, pc, ae, va};
    @(posedge clk);
    exc <= '0;
  endtask

  task automatic pulse(input logic is_rfe);
    @(posedge clk);
    rfe         <= is_rfe;
    dcache_miss <= ~is_rfe;
    @(posedge clk);
    rfe         <= 1'b0;
    dcache_miss <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  initial
  begin
    {psel, penable, pwrite, rfe, dcache_miss, strap} = '0;
    {paddr, pwdata, irq_pending, mismatches, compares, cycles} = '0;
    exc = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(PSW, 32'h0060_0000);
    settle(1);
    chk(32'({ctl.kernel, ctl.vec_uncached}), 32'h0000_0003);
    apb(1'b1, PSW, 32'hF25B_FF3F);
    rd_chk(PSW, 32'hF26B_FF3F);
    settle(1);
    chk(32'({ctl.swap, ctl.isolate, ctl.user_flip, ctl.kernel, big_endian_now, cop_permit}), 32'h1DF);
    apb(1'b1, PSW, 32'h3000_0002);
    settle(1);
    chk(32'({big_endian_now, ctl.vec_uncached, ctl.swap, cop_permit}), 32'h0000_0003);
    chk(32'(ctl.cu), 32'h0000_0003);
    apb(1'b1, PSW, 32'h0200_0000);
    settle(1);
    chk(32'({big_endian_now, ctl.kernel, cop_permit}), 32'h0000_001F);
    apb(1'b1, PSW, 32'h0001_0000);
    pulse(1'b0);
    rd_chk(PSW, 32'h0029_0000);
    apb(1'b1, PSW, 32'h0000_0000);
    pulse(1'b0);
    rd_chk(PSW, 32'h0020_0000);
    apb(1'b1, PSW, 32'h0000_0007);
    excp(1'b0, 32'h8000_1234, 1'b1, 32'hDEAD_BEE1);
    rd_chk(PSW, 32'h0020_001C);
    rd_chk(ERA, 32'h8000_1234);
    rd_chk(FVA, 32'hDEAD_BEE1);
    excp(1'b1, 32'h0000_2008, 1'b0, 32'h1111_1111);
    rd_chk(ERA, 32'h0000_2004);
    rd_chk(FVA, 32'hDEAD_BEE1);
    rd_chk(PSW, 32'h0020_0030);
    pulse(1'b1);
    rd_chk(PSW, 32'h0020_003C);
    pulse(1'b1);
    rd_chk(PSW, 32'h0020_003F);
    apb(1'b1, ERA, 32'h0000_0000);
    rd_chk(ERA, 32'h0000_2004);
    // Return in the cycle right after the exception
    @(posedge clk);
    exc <= '{1'b1, 1'b0, 32'h0000_3000, 1'b0, 32'h0000_0000};
    @(posedge clk);
    exc <= '0;
    rfe <= 1'b1;
    @(posedge clk);
    rfe <= 1'b0;
    rd_chk(PSW, 32'h0020_003F);
    rd_chk(ERA, 32'h0000_3000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    // Reset again from a dirty state, with the opposite byte order strap
    @(posedge clk);
    rst   <= 1'b1;
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(PSW, 32'h0060_0000);
    settle(1);
    chk(32'({ctl.kernel, ctl.vec_uncached, ctl.swap, big_endian_now}), 32'h0000_000D);
    apb(1'b1, PSW, 32'h0200_0002);
    settle(1);
    chk(32'({big_endian_now, ctl.user_flip, ctl.kernel}), 32'h0000_0002);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, PSW, 32'h0000_0001 | (32'h0000_0100 << i));
      irq_pending <= 8'h01 << i;
      settle(2);
      chk(32'(irq_request), 32'h0000_0001);
      @(posedge clk);
      irq_pending <= ~(8'h01 << i);
      settle(2);
      chk(32'(irq_request), 32'h0000_0000);
    end
    apb(1'b1, PSW, 32'h0000_FF00);
    irq_pending <= 8'hFF;
    settle(2);
    chk(32'(irq_request), 32'h0000_0000);
    wrap_up();
  end
endmodule // tb
